// file: src/origin_set_command.v
`timescale 1ns/1ps
`default_nettype none
`include "origin_set_consts.vh"

module origin_set_command #(
    parameter POS_W = `POS_W
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_b,
    // Register port
    input  wire [3:0]       addr,
    input  wire [31:0]      wdata,
    input  wire             wr,
    input  wire             rd,
    output reg  [31:0]      rdata,
    // Axis feedback
    input  wire [POS_W-1:0] feedback_pos,
    input  wire             axis_moving,
    // Axis outputs
    output reg              stop_motion,
    output reg              irq
);
    // =====================================
    // Software registers
    reg [15:0]      run_mode_word;
    reg [15:0]      servo_command_word;
    reg [15:0]      motion_command_word;
    reg [15:0]      fix3;
    reg [15:0]      fix14;
    reg [15:0]      fix17;
    reg [15:0]      motion_status_word;
    reg [POS_W-1:0] origin_offset;
    reg [`IRQ_W-1:0] irq_status;
    reg [`IRQ_W-1:0] irq_mask;

    // =====================================
    // Synchronised axis feedback
    // Each position bit passes two flops; the position must be quasi-static
    // around a set-origin command, as no word handshake is used
    reg [POS_W-1:0] pos_s1;
    reg [POS_W-1:0] pos_s2;
    reg             mov_s1;
    reg             mov_s2;

    genvar b;
    generate
        for (b = 0; b < POS_W; b = b + 1) begin : g_pos_sync
            always @(posedge clk) begin
                if (!rst_b) begin
                    pos_s1[b] <= 1'b0;
                    pos_s2[b] <= 1'b0;
                end else begin
                    pos_s1[b] <= feedback_pos[b];
                    pos_s2[b] <= pos_s1[b];
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (!rst_b) begin
            mov_s1 <= 1'b0;
            mov_s2 <= 1'b0;
        end else begin
            mov_s1 <= axis_moving;
            mov_s2 <= mov_s1;
        end
    end

    // =====================================
    // Command decode
    wire set_origin_cmd;

    cmd_edge_detect #(
        .W (`CMD_W)
    ) u_edge (
        .clk     (clk),
        .rst_b   (rst_b),
        .code    (motion_command_word),
        .target  (`CMD_SET_ORIGIN),
        .entered (set_origin_cmd)
    );

    // The command word is only acted on while both enables are set
    wire cmd_code_on  = run_mode_word[`RUN_CMD_ENABLE_BIT];
    wire cmd_word_use = fix14[`FIX14_CMD_USE_BIT];
    wire cmd_enabled  = cmd_code_on & cmd_word_use;
    wire position_mode_select = run_mode_word[`RUN_POS_MODE_BIT];
    // Servo-on state deliberately plays no part in the decision
    // An absolute encoder on an endless axis cannot take a new origin in motion
    wire abs_encoder  = (fix3 == `ENC_ABSOLUTE);
    wire endless_axis = fix17[`FIX17_INFINITE_BIT];
    wire refuse = abs_encoder & endless_axis & mov_s2;
    wire fire    = set_origin_cmd & cmd_enabled & position_mode_select;
    wire do_set  = fire & ~refuse;
    wire do_ref  = fire & refuse;
    wire is_nop  = (motion_command_word == `CMD_NOP);

    wire [POS_W-1:0] machine_pos = pos_s2 - origin_offset;

    // =====================================
    // Software register writes
    always @(posedge clk) begin
        if (!rst_b) begin
            run_mode_word       <= `WORD_ZERO;
            servo_command_word  <= `WORD_ZERO;
            motion_command_word <= `CMD_NOP;
            fix3                <= `WORD_ZERO;
            fix14               <= `WORD_ZERO;
            fix17               <= `WORD_ZERO;
            irq_mask            <= {`IRQ_W{1'b0}};
        end else if (wr) begin
            case (addr)
                `A_RUN_MODE:   run_mode_word       <= wdata[`WORD_W-1:0];
                `A_SERVO_CMD:  servo_command_word  <= wdata[`WORD_W-1:0];
                `A_MOTION_CMD: motion_command_word <= wdata[`WORD_W-1:0];
                `A_FIX3:       fix3                <= wdata[`WORD_W-1:0];
                `A_FIX14:      fix14               <= wdata[`WORD_W-1:0];
                `A_FIX17:      fix17               <= wdata[`WORD_W-1:0];
                `A_IRQ_MASK:   irq_mask            <= wdata[`IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // =====================================
    // Origin load and completion flags
    // The origin is the synchronised position, two clocks behind the pin
    always @(posedge clk) begin
        if (!rst_b) begin
            origin_offset      <= `POS_ZERO;
            motion_status_word <= `WORD_ZERO;
        end else if (do_set) begin
            origin_offset <= pos_s2;
            motion_status_word[`STAT_ORIGIN_SET_BIT] <= 1'b1;
            motion_status_word[`STAT_HOME_DONE_BIT]  <= 1'b1;
        end
    end

    // =====================================
    // Idle command stops the axis
    always @(posedge clk) begin
        if (!rst_b) begin
            stop_motion <= 1'b0;
        end else begin
            stop_motion <= is_nop & cmd_enabled;
        end
    end

    // =====================================
    // Interrupt status and output
    // A clear meeting a new event in one cycle loses, so no event is missed
    reg [`IRQ_W-1:0] events;
    reg [`IRQ_W-1:0] next_irq_status;
    always @* begin
        events          = {do_ref, do_set};
        next_irq_status = irq_status;
        if (wr && addr == `A_IRQ_STATUS) begin
            next_irq_status = irq_status & ~wdata[`IRQ_W-1:0];
        end
        next_irq_status = next_irq_status | events;
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            irq_status <= {`IRQ_W{1'b0}};
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq        <= |(next_irq_status & irq_mask);
        end
    end

    // =====================================
    // Read port
    // Read data stand in the cycle after each rd cycle and are zero otherwise
    reg [`DATA_W-1:0] next_rdata;
    always @* begin
        next_rdata = `DATA_ZERO;
        if (rd) begin
            case (addr)
                `A_RUN_MODE:    next_rdata = {`WORD_ZERO, run_mode_word};
                `A_SERVO_CMD:   next_rdata = {`WORD_ZERO, servo_command_word};
                `A_MOTION_CMD:  next_rdata = {`WORD_ZERO, motion_command_word};
                `A_FIX3:        next_rdata = {`WORD_ZERO, fix3};
                `A_FIX14:       next_rdata = {`WORD_ZERO, fix14};
                `A_FIX17:       next_rdata = {`WORD_ZERO, fix17};
                `A_STATUS:      next_rdata = {`WORD_ZERO, motion_status_word};
                `A_IRQ_STATUS:  next_rdata = {{(`DATA_W-`IRQ_W){1'b0}}, irq_status};
                `A_IRQ_MASK:    next_rdata = {{(`DATA_W-`IRQ_W){1'b0}}, irq_mask};
                `A_OFFSET:      next_rdata = origin_offset;
                `A_MACHINE_POS: next_rdata = machine_pos;
                default:        next_rdata = `DATA_ZERO;
            endcase
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            rdata <= `DATA_ZERO;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule // origin_set_command

`default_nettype wire

// file: src/origin_set_consts.vh
`ifndef ORIGIN_SET_CONSTS_VH
`define ORIGIN_SET_CONSTS_VH

// =====================================
// Command codes and word layouts
`define CMD_W               16
`define CMD_NOP             16'h0000
`define CMD_SET_ORIGIN      16'h0009
`define RUN_POS_MODE_BIT    2
`define RUN_CMD_ENABLE_BIT  8
`define SERVO_ON_BIT        0
`define STAT_ORIGIN_SET_BIT 3
`define STAT_HOME_DONE_BIT  6
`define FIX14_CMD_USE_BIT   7
`define FIX17_INFINITE_BIT  5
`define ENC_ABSOLUTE        16'h0001
`define POS_W               32
`define POS_ZERO            32'h0000_0000
`define WORD_W              16
`define WORD_ZERO           16'h0000
`define DATA_W              32
`define DATA_ZERO           32'h0000_0000

// =====================================
// Register map of the command port
`define ADDR_W              4
`define A_RUN_MODE          4'h0
`define A_SERVO_CMD         4'h1
`define A_MOTION_CMD        4'h2
`define A_FIX3              4'h3
`define A_FIX14             4'h4
`define A_FIX17             4'h5
`define A_STATUS            4'h6
`define A_IRQ_STATUS        4'h7
`define A_IRQ_MASK          4'h8
`define A_OFFSET            4'h9
`define A_MACHINE_POS       4'hA
`define IRQ_DONE_BIT        0
`define IRQ_REFUSED_BIT     1
`define IRQ_W               2

`endif

// file: src/cmd_edge_detect.v
`timescale 1ns/1ps
`default_nettype none
`include "origin_set_consts.vh"

// =====================================
// Rising-edge detector for entry into one command code
module cmd_edge_detect #(
    parameter W = `CMD_W
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_b,
    // Command word and code to watch
    input  wire [W-1:0] code,
    input  wire [W-1:0] target,
    // Entry pulse
    output reg          entered
);
    reg was_match;
    wire match = (code == target);

    always @(posedge clk) begin
        if (!rst_b) begin
            was_match <= 1'b0;
            entered   <= 1'b0;
        end else begin
            was_match <= match;
            entered   <= match & ~was_match;
        end
    end
endmodule // cmd_edge_detect

`default_nettype wire

// file: tb/origin_set_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module origin_set_checker (
    // Bus
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [3:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    // Axis
    input wire logic [31:0] feedback_pos,
    input wire logic        axis_moving,
    input wire logic        stop_motion,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence code_leaves_nop;
        wr && addr == 4'h2 && wdata[15:0] != 16'h0;
    endsequence
    read_idle_a: assert property (!rd |=> rdata == 32'h0)
        else $error("rdata not idle");
    status_bits_a: assert property (rd && addr == 4'h6 |=> (rdata & ~32'h48) == 0)
        else $error("stray status bit");
    unmapped_read_a: assert property (rd && addr > 4'hA |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    nop_stop_a: assert property (code_leaves_nop |=> ##1 !stop_motion)
        else $error("stop held off nop");
    enable_gate_a: assert property (wr && addr == 4'h0 && !wdata[8] |=> ##1 !stop_motion)
        else $error("stop while disabled");
    servo_ignore_a: assert property (wr && addr == 4'h1 |=> ##1 $stable(stop_motion))
        else $error("servo word moved stop");
    irq_cause_a: assert property ($rose(irq) |-> $past(wr && addr == 4'h8, 2)
        || $past(wr && addr == 4'h2 && wdata[15:0] == 16'h9, 3)) else $error("irq without cause");
endmodule // origin_set_checker

bind origin_set_command origin_set_checker origin_set_checker_inst (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .feedback_pos(feedback_pos), .axis_moving(axis_moving),
    .stop_motion(stop_motion), .irq(irq));
`default_nettype wire

// file: tb/ladder_program.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Program side of the command port
module ladder_program (
    // Bus
    input  wire logic        clk,
    input  wire logic [31:0] rdata,
    output var  logic [3:0]  addr,
    output var  logic [31:0] wdata,
    output var  logic        wr,
    output var  logic        rd
);
    initial {addr, wdata, wr, rd} = '0;
    task automatic put(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic get(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
endmodule // ladder_program
`default_nettype wire

// file: tb/origin_set_command_bench.sv
`timescale 1ns/1ps
`default_nettype none
module origin_set_command_bench;
    logic        clk;
    logic        rst_b;
    logic        moving;
    logic        stop_motion;
    logic        irq;
    logic [3:0]  addr;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] pos;
    int          miscompares = 0;
    int          n_checks = 0;
    logic [35:0] rows [8] = '{36'h0_0104_0104, 36'h1_0001_0001,
        36'h3_0000_0000, 36'h4_0080_0080, 36'h5_0000_0000, 36'h8_0003_0003,
        36'h6_ffff_0000, 36'hf_ffff_0000};
    ladder_program prog (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd));
    origin_set_command origin_set_command_inst (.clk(clk), .rst_b(rst_b),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .feedback_pos(pos), .axis_moving(moving), .stop_motion(stop_motion), .irq(irq));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        prog.get(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic wait_irq;
        int n;
        n = 0;
        while (n < 20 && irq !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (irq !== 1'b1) begin
            chk("irq wait", 1, 0);
            report_and_stop();
        end
    endtask
    task automatic axis(input logic [31:0] p, input logic m);
        @(posedge clk);
        pos <= p;
        moving <= m;
        settle();
    endtask
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    initial begin
        rst_b = 0;
        pos = 32'h0000_1234;
        moving = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        settle();
        chk("stop", 0, stop_motion);
        for (int i = 0; i < 8; i++) begin
            prog.put(rows[i][35:32], {16'h0, rows[i][31:16]});
            rchk(rows[i][35:32], {16'h0, rows[i][15:0]});
        end
        prog.put(4'h2, 32'h9);
        wait_irq();
        rchk(4'h6, 32'h48);
        rchk(4'h9, 32'h1234);
        rchk(4'ha, 32'h0);
        prog.put(4'h7, 32'h3);
        prog.put(4'h2, 32'h9);
        settle();
        chk("irq", 0, irq);
        prog.put(4'h2, 32'h0);
        settle();
        chk("stop", 1, stop_motion);
        axis(32'h0000_0100, 0);
        prog.put(4'h1, 32'h0);
        prog.put(4'h2, 32'h9);
        wait_irq();
        rchk(4'h9, 32'h100);
        prog.put(4'h7, 32'h3);
        prog.put(4'h2, 32'h0);
        prog.put(4'h3, 32'h1);
        prog.put(4'h5, 32'h20);
        axis(32'h0000_0555, 1);
        prog.put(4'h2, 32'h9);
        wait_irq();
        rchk(4'h7, 32'h2);
        rchk(4'h9, 32'h100);
        rchk(4'ha, 32'h455);
        prog.put(4'h7, 32'h3);
        prog.put(4'h2, 32'h0);
        prog.put(4'h0, 32'h4);
        prog.put(4'h2, 32'h9);
        settle();
        chk("irq", 0, irq);
        prog.put(4'h2, 32'h0);
        prog.put(4'h0, 32'h100);
        prog.put(4'h2, 32'h9);
        settle();
        chk("irq", 0, irq);
        prog.put(4'h2, 32'h0);
        prog.put(4'h0, 32'h104);
        prog.put(4'h4, 32'h0);
        prog.put(4'h2, 32'h9);
        settle();
        chk("irq", 0, irq);
        report_and_stop();
    end
endmodule // origin_set_command_bench
`default_nettype wire
